// file: bench/daq_timing_trigger_io_tb_top.sv
`timescale 1ns/1ps
`include "dtt_consts.svh"
module daq_timing_trigger_io_tb_top
   import dtt_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [23:0] dio_in = 24'h00_0000;
   logic [31:0] hrdata;
   logic hready;
   logic pin37;
   logic pin3;
   dtt_pins_s pins;
   dtt_evt_s evt;
   logic [23:0] dio_out;
   logic [23:0] dio_oe;
   logic [3:0] src;
   logic rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] d;
   logic [1:0] m;
   int num_errors = 0;
   int tests_run = 0;
   int seed = 88;
   int nconv = 0;
   int nprim = 0;
   int nsec = 0;
   int n0;
   int k;
   always #20 clk = ~clk;
   dtt_top i_dtt_top (.ref_clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
      .adc_ext_pacer_in_i(src[0]), .adc_trigger_gate_in_i(src[1]),
      .dac_ext_pacer_in_i(src[2]), .dac_trigger_gate_in_i(src[3]), .pin37_o(pin37),
      .pin3_o(pin3), .pins_o(pins), .evt_o(evt), .dio_in_i(dio_in), .dio_out_o(dio_out),
      .dio_oe_o(dio_oe));
   dtt_src_model i_dtt_src_model (.clk_i(clk), .pin_o(src));
   // ----
   // checking and bus tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] dat);
      @(posedge clk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] dat);
      bus(a, 1'b1, dat);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 32'h0000_0000);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   function automatic logic pick(input int s);
      return s ? pin37 : pin3;
   endfunction
   task automatic meas(input int s, input int hi, input int lo);
      int h = 0;
      int l = 0;
      int w = 0;
      while (pick(s) !== 1'b0 && w < 500) begin
         @(negedge clk);
         w++;
      end
      while (pick(s) !== 1'b1 && w < 500) begin
         @(negedge clk);
         w++;
      end
      while (pick(s) === 1'b1 && h < 500) begin
         @(negedge clk);
         h++;
      end
      while (pick(s) === 1'b0 && l < 500) begin
         @(negedge clk);
         l++;
      end
      check(h, hi);
      check(l, lo);
   endtask
   // ----
   // read watcher and event counters
   // ----
   always @(posedge clk) begin
      if (rd_ph && hready) check(hrdata, exp_q.pop_front());
      rd_ph <= htrans[1] && !hwrite && hready;
      if (evt.adc_conv) nconv++;
      if (evt.dac_primary_upd) nprim++;
      if (evt.dac_secondary_upd) nsec++;
   end
   initial begin
      #2_000_000;
      num_errors++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wr(32'h0000_0040, 32'hffff_ffff);
      rd(`DTT_A_CTRL, `DTT_RST_CTRL);
      rd(`DTT_A_T0, 32'h0000_0001);
      rd(`DTT_A_T1, 32'h0000_0001);
      rd(`DTT_A_CNT1, 32'h0000_0000);
      rd(32'h0000_0040, 32'h0000_0000);
      @(posedge clk);
      dio_in <= 24'($random(seed));
      d = $random(seed);
      wr(`DTT_A_DIO_DIR, 32'h0000_0005);
      wr(`DTT_A_DIO_OUT, d);
      wr(`DTT_A_DIO_IN, ~d);
      cyc(2);
      check(dio_oe, 24'hff_00ff);
      check(dio_out & 24'hff_00ff, d[23:0] & 24'hff_00ff);
      rd(`DTT_A_DIO_IN, {8'h00, dio_in});
      wr(`DTT_A_T0, 32'h0000_0004);
      wr(`DTT_A_T1, 32'h0000_0002);
      wr(`DTT_A_CTRL, 32'h0000_00c0);
      meas(0, 50, 50);
      meas(1, 25, 25);
      wr(`DTT_A_CTRL, 32'h0000_00f0);
      cyc(3);
      k = 0;
      repeat (200) begin
         @(negedge clk);
         if ((pins.timer_zero_out | pins.timer_one_out | pin3 | pin37) !== 1'b0) k++;
      end
      check(k, 0);
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 2'h2 : (i == 1) ? 2'h3 : (i == 2) ? 2'h1 : 2'h0;
         if (m == 2'h0) begin
            @(posedge clk);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
         end
         i_dtt_src_model.set_pin(1, m[0]);
         wr(`DTT_A_CTRL, 32'h0000_0030 | (32'(m) << 2));
         cyc(8);
         check(evt.adc_run, 1'b0);
         i_dtt_src_model.set_pin(1, ~m[0]);
         cyc(8);
         check(evt.adc_run, 1'b1);
      end
      n0 = nconv;
      wr(`DTT_A_CMD, 32'h0000_0001);
      cyc(40);
      check(nconv, n0 + 1);
      for (int e = 0; e < 2; e++) begin
         i_dtt_src_model.set_pin(0, ~e[0]);
         wr(`DTT_A_CTRL, 32'h0000_0032 | e);
         cyc(30);
         n0 = nconv;
         i_dtt_src_model.set_pin(0, e[0]);
         cyc(40);
         check(nconv, n0);
         i_dtt_src_model.set_pin(0, ~e[0]);
         cyc(6);
         check(pin37, 1'b1);
         cyc(40);
         check(nconv, n0 + 1);
      end
      i_dtt_src_model.set_pin(3, 1'b1);
      wr(`DTT_A_DAC, 32'h0000_000a);
      wr(`DTT_A_CTRL, 32'h0000_1400);
      cyc(8);
      check(evt.dac_run, 1'b1);
      i_dtt_src_model.pulses(2, 3, 30);
      cyc(8);
      check(nprim, 3);
      check(nsec, 3);
      rd(`DTT_A_CNT1, 32'h0000_0003);
      wr(`DTT_A_CTRL, 32'h0000_1500);
      i_dtt_src_model.pulses(2, 1, 30);
      cyc(8);
      check(nprim, 4);
      rd(`DTT_A_CNT1, 32'h0000_0004);
      wr(`DTT_A_DAC, 32'h0000_0002);
      wr(`DTT_A_CMD, 32'h0000_0004);
      cyc(8);
      check(nsec, 5);
      check(nprim, 4);
      wr(`DTT_A_DAC, 32'h0020_0035);
      cyc(100);
      n0 = nprim;
      k = nsec;
      cyc(600);
      check(nprim - n0, 12);
      check(nsec - k, 8);
      i_dtt_src_model.set_pin(3, 1'b0);
      cyc(8);
      check(evt.dac_run, 1'b0);
      cyc(4);
      end_of_test;
   end
endmodule
bind dtt_top dtt_top_chk i_dtt_top_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pin37_o(pin37_o), .pin3_o(pin3_o),
   .pins_o(pins_o), .evt_o(evt_o), .dio_oe_o(dio_oe_o));

// file: bench/dtt_src_model.sv
`timescale 1ns/1ps
module dtt_src_model (
   input wire logic clk_i,
   output logic [3:0] pin_o
);
   // 0 adc pacer, 1 adc gate, 2 dac pacer and counter one, 3 dac gate
   // each line driven from one source on one pin position only
   initial pin_o = 4'h0;
   task automatic set_pin(input int idx, input logic v);
      @(posedge clk_i);
      pin_o[idx] <= v;
   endtask
   task automatic pulses(input int idx, input int n, input int half);
      int h;
      h = (half < 25) ? 25 : half;
      repeat (n) begin
         set_pin(idx, 1'b1);
         repeat (h) @(posedge clk_i);
         set_pin(idx, 1'b0);
         repeat (h) @(posedge clk_i);
      end
   endtask
endmodule

// file: bench/dtt_top_chk.sv
`timescale 1ns/1ps
module dtt_top_chk
   import dtt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic pin37_o,
   input wire logic pin3_o,
   input wire dtt_pins_s pins_o,
   input wire dtt_evt_s evt_o,
   input wire logic [23:0] dio_oe_o
);
   // ----
   // pulse width counters
   // ----
   logic [7:0] ck_r;
   logic [7:0] ck_nxt;
   logic [7:0] tg_r;
   logic [7:0] tg_nxt;
   always_comb begin
      ck_nxt = pins_o.adc_clock_pulse_out ? ck_r + 8'h01 : 8'h00;
      tg_nxt = pins_o.adc_trigger_pulse_out ? tg_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ck_r <= 8'h00;
         tg_r <= 8'h00;
      end else begin
         ck_r <= ck_nxt;
         tg_r <= tg_nxt;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence conv_s;
      $rose(evt_o.adc_conv);
   endsequence
   sequence start_s;
      $rose(evt_o.adc_run);
   endsequence
   bus_okay_a: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready or not okay");
   dio_group_a: assert property ((dio_oe_o[7:0] == 8'h00 || dio_oe_o[7:0] == 8'hff) &&
      (dio_oe_o[15:8] == 8'h00 || dio_oe_o[15:8] == 8'hff) &&
      (dio_oe_o[23:16] == 8'h00 || dio_oe_o[23:16] == 8'hff))
      else $error("digital group direction split");
   t1_pin_a: assert property (pins_o.timer_one_out |-> pin37_o && pins_o.pin37 == pin37_o)
      else $error("timer one not alone on its pin");
   t0_pin_a: assert property (pins_o.timer_zero_out |-> pin3_o && pins_o.pin3 == pin3_o)
      else $error("timer zero not alone on its pin");
   conv_pulse_a: assert property (conv_s |-> ##[0:2] pins_o.adc_clock_pulse_out)
      else $error("conversion without clock pulse");
   clk_width_a: assert property ($fell(pins_o.adc_clock_pulse_out) |-> ck_r inside {[25:26]})
      else $error("clock pulse width wrong");
   trg_pulse_a: assert property (start_s |-> ##[0:2] pins_o.adc_trigger_pulse_out)
      else $error("trigger without trigger pulse");
   trg_width_a: assert property ($fell(pins_o.adc_trigger_pulse_out) |-> tg_r inside {[25:26]})
      else $error("trigger pulse width wrong");
   conv_single_a: assert property (evt_o.adc_conv |=> !evt_o.adc_conv)
      else $error("conversion strobe longer than one cycle");
endmodule

// file: design/dtt_consts.svh
// Operation
// - secondary DAC: software, ADC pacer, or primary clock
// - primary DAC: software, own pacer, or external clock
// - 24 digital lines, three 8-bit direction groups
// - ADC external pacer edge, rising or falling
// - ADC clock pulse output high one microsecond
// - timer one: independent pacer like timer zero
// - clock pulse enable forces timer one off
// - ADC trigger/gate: edge or level, either polarity
// - ADC trigger pulse output high one microsecond
// - timer zero square wave, 1 to 65535 us; code rounds the period up to even, 2 to 65536 us
// - trigger pulse enable forces timer zero off
// - DAC external pacer edge, rising or falling
// - counter one counts rising edges, max 500 kHz
// - counter one shares external DAC clock input
// - DAC trigger/gate: edge or level, either polarity
`ifndef DTT_CONSTS_SVH
`define DTT_CONSTS_SVH
`define DTT_CLK_MHZ 25
`define DTT_US_NS 1000
`define DTT_CLK_NS 40
`define DTT_US_CYC (`DTT_US_NS / `DTT_CLK_NS)
`define DTT_A_CTRL 32'h0000_0000
`define DTT_A_T0 32'h0000_0004
`define DTT_A_T1 32'h0000_0008
`define DTT_A_DAC 32'h0000_000C
`define DTT_A_DIO_DIR 32'h0000_0010
`define DTT_A_DIO_OUT 32'h0000_0014
`define DTT_A_DIO_IN 32'h0000_0018
`define DTT_A_CNT1 32'h0000_001C
`define DTT_A_CMD 32'h0000_0020
`define DTT_A_STAT 32'h0000_0024
`define DTT_B_ADC_EDGE 0
`define DTT_B_ADC_SRC 1
`define DTT_B_ATRG_LO 2
`define DTT_B_ATRG_HI 3
`define DTT_B_CLKOUT_EN 4
`define DTT_B_TRGOUT_EN 5
`define DTT_B_T0_EN 6
`define DTT_B_T1_EN 7
`define DTT_B_DAC_EDGE 8
`define DTT_B_DTRG_LO 9
`define DTT_B_DTRG_HI 10
`define DTT_B_DAC_EXT 11
`define DTT_B_CNT1_EN 12
`define DTT_B_P_SRC_LO 0
`define DTT_B_S_SRC_LO 2
`define DTT_B_ADC_PACER_LO 4
`define DTT_B_DAC_PRIMARY_PACER_LO 20
`define DTT_B_CMD_ADC 0
`define DTT_B_CMD_DAC_PRIMARY 1
`define DTT_B_CMD_DAC_SECONDARY 2
`define DTT_RST_PERIOD 16'h0001
`define DTT_RST_CTRL 32'h0000_0000
`endif

// file: design/dtt_pkg.sv
package dtt_pkg;
   typedef enum logic [1:0] {DTT_TRG_RISE, DTT_TRG_FALL, DTT_TRG_HIGH, DTT_TRG_LOW} dtt_trg_e;
   typedef enum logic [1:0] {DTT_P_SW, DTT_P_PACER, DTT_P_EXT} dtt_psrc_e;
   typedef enum logic [1:0] {DTT_S_SW, DTT_S_PACER, DTT_S_PRIM} dtt_ssrc_e;
   typedef struct packed {
      logic adc_clock_pulse_out;
      logic adc_trigger_pulse_out;
      logic timer_zero_out;
      logic timer_one_out;
      logic pin37;
      logic pin3;
   } dtt_pins_s;
   typedef struct packed {
      logic adc_conv;
      logic adc_run;
      logic dac_primary_upd;
      logic dac_secondary_upd;
      logic dac_run;
   } dtt_evt_s;
endpackage

// file: design/dtt_top.sv
`timescale 1ns/1ps
`include "dtt_consts.svh"
module dtt_top
   import dtt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic adc_ext_pacer_in_i,
   input wire logic adc_trigger_gate_in_i,
   input wire logic dac_ext_pacer_in_i,
   input wire logic dac_trigger_gate_in_i,
   output logic pin37_o,
   output logic pin3_o,
   output dtt_pins_s pins_o,
   output dtt_evt_s evt_o,
   input wire logic [23:0] dio_in_i,
   output logic [23:0] dio_out_o,
   output logic [23:0] dio_oe_o
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [3:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
   logic [23:0] d1_r, d2_r, d1_nxt, d2_nxt;
   always_comb begin
      s1_nxt = {dac_trigger_gate_in_i, dac_ext_pacer_in_i, adc_trigger_gate_in_i,
                adc_ext_pacer_in_i};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      d1_nxt = dio_in_i;
      d2_nxt = d1_r;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         d1_r <= 24'h00_0000;
         d2_r <= 24'h00_0000;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         d1_r <= d1_nxt;
         d2_r <= d2_nxt;
      end
   end
   logic [3:0] rise, fall;
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;

   // ------------------------------------------------------------
   // registers and bus slave
   // ------------------------------------------------------------
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [15:0] t0p_r, t0p_nxt, t1p_r, t1p_nxt;
   logic [31:0] dac_r, dac_nxt;
   logic [2:0] dir_r, dir_nxt;
   logic [23:0] dout_r, dout_nxt;
   logic [31:0] cnt1_r, cnt1_nxt;
   logic [2:0] cmd_r, cmd_nxt;
   logic wph_r, wph_nxt, rph_r, rph_nxt;
   logic [31:0] addr_r, addr_nxt, rdata_r, rdata_nxt;
   logic adc_run_r, dac_run_r, adc_run_nxt, dac_run_nxt;
   logic cnt1_inc;
   logic [31:0] rd_mux;
   logic take;
   assign take = hsel_i & hready_i & htrans_i[1];
   always_comb begin
      unique case (haddr_i)
         `DTT_A_CTRL: rd_mux = ctrl_r;
         `DTT_A_T0: rd_mux = {16'h0000, t0p_r};
         `DTT_A_T1: rd_mux = {16'h0000, t1p_r};
         `DTT_A_DAC: rd_mux = dac_r;
         `DTT_A_DIO_DIR: rd_mux = {29'h0000_0000, dir_r};
         `DTT_A_DIO_OUT: rd_mux = {8'h00, dout_r};
         `DTT_A_DIO_IN: rd_mux = {8'h00, d2_r};
         `DTT_A_CNT1: rd_mux = cnt1_r;
         `DTT_A_STAT: rd_mux = {30'h0000_0000, dac_run_r, adc_run_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_comb begin
      ctrl_nxt = ctrl_r;
      t0p_nxt = t0p_r;
      t1p_nxt = t1p_r;
      dac_nxt = dac_r;
      dir_nxt = dir_r;
      dout_nxt = dout_r;
      cmd_nxt = 3'h0;
      cnt1_nxt = cnt1_inc ? cnt1_r + 32'h0000_0001 : cnt1_r;
      wph_nxt = take & hwrite_i;
      rph_nxt = take & ~hwrite_i;
      addr_nxt = take ? haddr_i : addr_r;
      rdata_nxt = (take & ~hwrite_i) ? rd_mux : rdata_r;
      if (wph_r) begin
         unique case (addr_r)
            `DTT_A_CTRL: ctrl_nxt = hwdata_i;
            `DTT_A_T0: t0p_nxt = hwdata_i[15:0];
            `DTT_A_T1: t1p_nxt = hwdata_i[15:0];
            `DTT_A_DAC: dac_nxt = hwdata_i;
            `DTT_A_DIO_DIR: dir_nxt = hwdata_i[2:0];
            `DTT_A_DIO_OUT: dout_nxt = hwdata_i[23:0];
            `DTT_A_CNT1: cnt1_nxt = hwdata_i;
            `DTT_A_CMD: cmd_nxt = hwdata_i[2:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= `DTT_RST_CTRL;
         t0p_r <= `DTT_RST_PERIOD;
         t1p_r <= `DTT_RST_PERIOD;
         dac_r <= 32'h0000_0000;
         dir_r <= 3'h0;
         dout_r <= 24'h00_0000;
         cnt1_r <= 32'h0000_0000;
         cmd_r <= 3'h0;
         wph_r <= 1'b0;
         rph_r <= 1'b0;
         addr_r <= 32'h0000_0000;
         rdata_r <= 32'h0000_0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         t0p_r <= t0p_nxt;
         t1p_r <= t1p_nxt;
         dac_r <= dac_nxt;
         dir_r <= dir_nxt;
         dout_r <= dout_nxt;
         cnt1_r <= cnt1_nxt;
         cmd_r <= cmd_nxt;
         wph_r <= wph_nxt;
         rph_r <= rph_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_r;

   // ------------------------------------------------------------
   // digital port groups
   // ------------------------------------------------------------
   always_comb begin
      for (int g = 0; g < 3; g++) begin
         dio_oe_o[g*8 +: 8] = {8{dir_r[g]}};
      end
   end
   assign dio_out_o = dout_r;

   // ------------------------------------------------------------
   // microsecond timebase and pacers
   // ------------------------------------------------------------
   localparam logic [4:0] US_LAST = 5'(`DTT_US_CYC - 1);
   logic [4:0] pre_r, pre_nxt;
   logic tick;
   assign tick = (pre_r == US_LAST);
   always_comb pre_nxt = tick ? 5'h00 : pre_r + 5'h01;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) pre_r <= 5'h00;
      else pre_r <= pre_nxt;
   end

   logic t0_off, t1_off;
   logic [15:0] h0_r, h0_nxt, h1_r, h1_nxt, ap_r, ap_nxt, dp_r, dp_nxt;
   logic [15:0] ap_per, dp_per;
   logic q0_r, q0_nxt, q1_r, q1_nxt;
   logic ap_tk, dp_tk;
   assign t0_off = ~ctrl_r[`DTT_B_T0_EN] | ctrl_r[`DTT_B_TRGOUT_EN];
   assign t1_off = ~ctrl_r[`DTT_B_T1_EN] | ctrl_r[`DTT_B_CLKOUT_EN];
   assign ap_per = dac_r[`DTT_B_ADC_PACER_LO +: 16];
   assign dp_per = dac_r[`DTT_B_DAC_PRIMARY_PACER_LO +: 12] == 12'h000 ? 16'h0001
                   : {4'h0, dac_r[`DTT_B_DAC_PRIMARY_PACER_LO +: 12]};
   // timers toggle every half period; full period = t0p us rounded up to an even count, in 2 us steps
   always_comb begin
      h0_nxt = h0_r;
      q0_nxt = q0_r;
      h1_nxt = h1_r;
      q1_nxt = q1_r;
      ap_nxt = ap_r;
      dp_nxt = dp_r;
      ap_tk = 1'b0;
      dp_tk = 1'b0;
      if (t0_off) begin
         h0_nxt = 16'h0000;
         q0_nxt = 1'b0;
      end else if (tick) begin
         // toggle once twice the tick count reaches the period (half rounded up)
         if (({h0_r, 1'b1} + 17'h0_0001) >= {1'b0, t0p_r}) begin
            h0_nxt = 16'h0000;
            q0_nxt = ~q0_r;
         end else h0_nxt = h0_r + 16'h0001;
      end
      if (t1_off) begin
         h1_nxt = 16'h0000;
         q1_nxt = 1'b0;
      end else if (tick) begin
         if (({h1_r, 1'b1} + 17'h0_0001) >= {1'b0, t1p_r}) begin
            h1_nxt = 16'h0000;
            q1_nxt = ~q1_r;
         end else h1_nxt = h1_r + 16'h0001;
      end
      if (tick) begin
         ap_tk = (ap_r + 16'h0001 >= ap_per) & (ap_per != 16'h0000);
         ap_nxt = ap_tk ? 16'h0000 : ap_r + 16'h0001;
         dp_tk = (dp_r + 16'h0001 >= dp_per);
         dp_nxt = dp_tk ? 16'h0000 : dp_r + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         h0_r <= 16'h0000;
         h1_r <= 16'h0000;
         q0_r <= 1'b0;
         q1_r <= 1'b0;
         ap_r <= 16'h0000;
         dp_r <= 16'h0000;
      end else begin
         h0_r <= h0_nxt;
         h1_r <= h1_nxt;
         q0_r <= q0_nxt;
         q1_r <= q1_nxt;
         ap_r <= ap_nxt;
         dp_r <= dp_nxt;
      end
   end

   // ------------------------------------------------------------
   // trigger/gate, conversion and DAC updates
   // ------------------------------------------------------------
   function automatic logic [1:0] trg(input dtt_trg_e m, input logic lv, input logic r,
                                      input logic f);
      // bit1 start, bit0 stop
      unique case (m)
         DTT_TRG_RISE: trg = {r, 1'b0};
         DTT_TRG_FALL: trg = {f, 1'b0};
         DTT_TRG_HIGH: trg = {lv, ~lv};
         DTT_TRG_LOW: trg = {~lv, lv};
      endcase
   endfunction
   logic [1:0] at, dt;
   logic adc_ext_evt, dac_ext_evt, adc_conv, adc_trig, p_upd, s_upd;
   logic cp_r, cp_nxt, tp_r, tp_nxt;
   logic [4:0] cpc_r, cpc_nxt, tpc_r, tpc_nxt;
   dtt_psrc_e psrc;
   dtt_ssrc_e ssrc;
   assign at = trg(dtt_trg_e'(ctrl_r[`DTT_B_ATRG_HI:`DTT_B_ATRG_LO]), s2_r[1], rise[1],
                   fall[1]);
   assign dt = trg(dtt_trg_e'(ctrl_r[`DTT_B_DTRG_HI:`DTT_B_DTRG_LO]), s2_r[3], rise[3],
                   fall[3]);
   assign adc_ext_evt = ctrl_r[`DTT_B_ADC_EDGE] ? fall[0] : rise[0];
   assign dac_ext_evt = ctrl_r[`DTT_B_DAC_EDGE] ? fall[2] : rise[2];
   assign adc_trig = at[1] & ~adc_run_r;
   assign adc_conv = adc_run_r & (ctrl_r[`DTT_B_ADC_SRC] ? adc_ext_evt
                     : (ap_tk | cmd_r[`DTT_B_CMD_ADC]));
   assign psrc = dtt_psrc_e'(dac_r[`DTT_B_P_SRC_LO +: 2]);
   assign ssrc = dtt_ssrc_e'(dac_r[`DTT_B_S_SRC_LO +: 2]);
   always_comb begin
      unique case (psrc)
         DTT_P_SW: p_upd = cmd_r[`DTT_B_CMD_DAC_PRIMARY];
         DTT_P_PACER: p_upd = dp_tk;
         DTT_P_EXT: p_upd = dac_ext_evt;
         default: p_upd = 1'b0;
      endcase
      unique case (ssrc)
         DTT_S_SW: s_upd = cmd_r[`DTT_B_CMD_DAC_SECONDARY];
         DTT_S_PACER: s_upd = ap_tk;
         DTT_S_PRIM: s_upd = p_upd;
         default: s_upd = 1'b0;
      endcase
      p_upd = p_upd & dac_run_r;
      s_upd = s_upd & dac_run_r;
   end
   // counter one counts the shared input's rising edges; with external DAC
   // pacing it can only be that same signal
   assign cnt1_inc = ctrl_r[`DTT_B_CNT1_EN] & rise[2];
   always_comb begin
      adc_run_nxt = at[1] ? 1'b1 : (at[0] ? 1'b0 : adc_run_r);
      dac_run_nxt = dt[1] ? 1'b1 : (dt[0] ? 1'b0 : dac_run_r);
      cp_nxt = cp_r;
      cpc_nxt = cpc_r;
      tp_nxt = tp_r;
      tpc_nxt = tpc_r;
      if (adc_conv) begin
         cp_nxt = 1'b1;
         cpc_nxt = US_LAST;
      end else if (cp_r) begin
         cpc_nxt = cpc_r - 5'h01;
         cp_nxt = (cpc_r != 5'h00);
      end
      if (adc_trig) begin
         tp_nxt = 1'b1;
         tpc_nxt = US_LAST;
      end else if (tp_r) begin
         tpc_nxt = tpc_r - 5'h01;
         tp_nxt = (tpc_r != 5'h00);
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         adc_run_r <= 1'b0;
         dac_run_r <= 1'b0;
         cp_r <= 1'b0;
         tp_r <= 1'b0;
         cpc_r <= 5'h00;
         tpc_r <= 5'h00;
      end else begin
         adc_run_r <= adc_run_nxt;
         dac_run_r <= dac_run_nxt;
         cp_r <= cp_nxt;
         tp_r <= tp_nxt;
         cpc_r <= cpc_nxt;
         tpc_r <= tpc_nxt;
      end
   end

   // ------------------------------------------------------------
   // shared output pins
   // ------------------------------------------------------------
   logic pa, pb, w0, w1;
   // a timer switched off drops its output in the same cycle, not one later
   assign w0 = q0_r & ~t0_off;
   assign w1 = q1_r & ~t1_off;
   assign pa = ctrl_r[`DTT_B_CLKOUT_EN] ? (cp_r & (cpc_r != 5'h00 || adc_conv)) : w1;
   assign pb = ctrl_r[`DTT_B_TRGOUT_EN] ? tp_r : w0;
   assign pin37_o = ctrl_r[`DTT_B_CLKOUT_EN] ? cp_r : w1;
   assign pin3_o = pb;
   assign pins_o = '{adc_clock_pulse_out: cp_r, adc_trigger_pulse_out: tp_r,
                     timer_zero_out: w0, timer_one_out: w1, pin37: pa | ~pa & pin37_o,
                     pin3: pb};
   assign evt_o = '{adc_conv: adc_conv, adc_run: adc_run_r, dac_primary_upd: p_upd,
                    dac_secondary_upd: s_upd, dac_run: dac_run_r};
endmodule
